// ---- atc_flush_decoder_bench.sv ----
// Self-checking bench for the translation cache flush decoder
`default_nettype none
module atc_flush_decoder_bench import atcfd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic                       sys_clk, rst, issue, supervisor, fill;
   logic                       done, priv_trap, illegal, flush_strobe;
   logic [15:0]                op_word, cmd_word;
   logic [31:0]                data_reg_value, eff_addr, flush_addr;
   logic [2:0]                 source_fc_register, dest_fc_register;
   logic [2:0]                 fill_index, fill_fc, data_reg_sel;
   logic [ATCFD_PAGE_BITS-1:0] fill_page;
   logic [ATCFD_ENTRIES-1:0]   entry_valid;
   logic [7:0]                 ea_ok;
   int                         n_fail, total_checks, m;
   // ----------------------------------------
   // Design and core model
   // ----------------------------------------
   atcfd_flush u_dut (.sys_clk(sys_clk), .rst(rst), .issue(issue),
      .op_word(op_word), .cmd_word(cmd_word), .supervisor(supervisor),
      .data_reg_value(data_reg_value), .eff_addr(eff_addr),
      .source_fc_register(source_fc_register),
      .dest_fc_register(dest_fc_register), .fill(fill),
      .fill_index(fill_index), .fill_fc(fill_fc), .fill_page(fill_page),
      .done(done), .priv_trap(priv_trap), .illegal(illegal),
      .data_reg_sel(data_reg_sel), .entry_valid(entry_valid),
      .flush_strobe(flush_strobe), .flush_addr(flush_addr));
   atcfd_core_model u_core (.cmd_word(cmd_word),
      .data_reg_value(data_reg_value),
      .source_fc_register(source_fc_register),
      .dest_fc_register(dest_fc_register));
   initial begin
      sys_clk = 1'h0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One flush, then an idle cycle so issue never toggles twice at once
   task automatic run(input logic [15:0] op, input logic [15:0] cmd,
                      input logic sup, input logic [31:0] ea,
                      input logic t, input logic il, input logic [7:0] v);
      op_word = op;
      cmd_word = cmd;
      supervisor = sup;
      eff_addr = ea;
      issue = 1'h1;
      @(negedge sys_clk);
      issue = 1'h0;
      chk(done, 32'h1);
      chk(priv_trap, t);
      chk(illegal, il);
      chk(flush_strobe, !(t | il));
      chk(entry_valid, v);
      chk(flush_addr, ea);
      @(negedge sys_clk);
      chk(done, 32'h0);
   endtask
   // Entry i gets code i; odd entries share one page, even another
   task automatic fill_all();
      for (int i = 0; i < 8; i++) begin
         fill_index = 3'(i);
         fill_fc = 3'(i);
         fill_page = 20'h12340 + 20'(i % 2);
         fill = 1'h1;
         @(negedge sys_clk);
      end
      fill = 1'h0;
      chk(entry_valid, 32'hFF);
   endtask
   task automatic finish_test();
      if (n_fail == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      rst = 1'h1;
      {issue, supervisor, fill, op_word, cmd_word, eff_addr} = '0;
      {fill_index, fill_fc, fill_page, n_fail, total_checks} = '0;
      ea_ok = 8'hE4;
      repeat (5) @(negedge sys_clk);
      rst = 1'h0;
      @(negedge sys_clk);
      chk(entry_valid, 32'h0);
      fill_all();
      run(16'hF000, 16'h2400, 1'h0, 32'h0, 1'h1, 1'h0, 8'hFF);
      run(16'hF000, 16'h3091, 1'h1, 32'h0, 1'h0, 1'h0, 8'hF0);
      run(16'hF000, 16'h30F5, 1'h1, 32'h0, 1'h0, 1'h0, 8'hD0);
      run(16'hF000, 16'h30EB, 1'h1, 32'h0, 1'h0, 1'h0, 8'hC0);
      chk(data_reg_sel, 32'h3);
      run(16'hF000, 16'h30E0, 1'h1, 32'h0, 1'h0, 1'h0, 8'h80);
      run(16'hF000, 16'h30E1, 1'h1, 32'h0, 1'h0, 1'h0, 8'h00);
      fill_all();
      // Stack pointer indirect: the address itself is flushed
      run(16'hF017, 16'h3810, 1'h1, 32'h12341ABC, 1'h0, 1'h0,
          8'h55);
      for (m = 0; m < 8; m++) begin
         run(16'hF000 | 16'(m << 3), 16'h3810, 1'h1, 32'h0, 1'h0,
             !ea_ok[m], 8'h55);
      end
      run(16'hF03A, 16'h3810, 1'h1, 32'h0, 1'h0, 1'h1, 8'h55);
      run(16'hF000, 16'h2800, 1'h1, 32'h0, 1'h0, 1'h1, 8'h55);
      run(16'hF400, 16'h2400, 1'h1, 32'h0, 1'h0, 1'h1, 8'h55);
      run(16'hF000, 16'h6400, 1'h1, 32'h0, 1'h0, 1'h1, 8'h55);
      run(16'hF000, 16'h3018, 1'h1, 32'h0, 1'h0, 1'h1, 8'h55);
      // Flush-all issued with mask and code zeroed
      run(16'hF000, 16'h2400, 1'h1, 32'h0, 1'h0, 1'h0,
          8'h00);
      finish_test();
   end
endmodule
`default_nettype wire

// ---- atcfd_core_model.sv ----
// Behavioural model of the core supplying register operands
`default_nettype none
module atcfd_core_model (
   // Command word from the core
   input  wire logic [15:0] cmd_word,
   // Register operands
   output logic      [31:0] data_reg_value,
   output logic      [2:0]  source_fc_register,
   output logic      [2:0]  dest_fc_register
);
   timeunit 1ns;
   timeprecision 1ps;
   // Upper bits busy so that only the low three bits may count
   assign data_reg_value = {29'h15555555, 3'h7 - cmd_word[2:0]};
   assign source_fc_register = 3'h6;
   assign dest_fc_register = 3'h7;
endmodule
`default_nettype wire

// ---- atcfd_flush.sv ----
// Translation cache flush decoder with its entry tag store
`default_nettype none
module atcfd_flush
   import atcfd_pkg::*;
(
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   // Instruction issue from the core
   input  wire logic                       issue,
   input  wire logic [15:0]                op_word,
   input  wire logic [15:0]                cmd_word,
   input  wire logic                       supervisor,
   input  wire logic [31:0]                data_reg_value,
   input  wire logic [2:0]                 source_fc_register,
   input  wire logic [2:0]                 dest_fc_register,
   input  wire logic [31:0]                eff_addr,
   // Translation cache fill port
   input  wire logic                       fill,
   input  wire logic [2:0]                 fill_index,
   input  wire logic [2:0]                 fill_fc,
   input  wire logic [ATCFD_PAGE_BITS-1:0] fill_page,
   // Results to the core
   output logic                            done,
   output logic                            priv_trap,
   output logic                            illegal,
   output logic [2:0]                      data_reg_sel,
   output logic [ATCFD_ENTRIES-1:0]        entry_valid,
   output logic                            flush_strobe,
   output logic [31:0]                     flush_addr
);

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   logic [2:0] ea_mode;
   logic [2:0] ea_reg;
   logic [2:0] opm;
   logic [2:0] mask;
   logic [4:0] fc_field;
   logic       op_ok;
   logic       ea_ok;
   logic       fc_ok;
   logic [2:0] fc_val;
   logic       fmt_ok;
   logic [ATCFD_ENTRIES-1:0] next_kill;

   assign ea_mode  = op_word[5:3];
   assign ea_reg   = op_word[2:0];
   assign opm      = cmd_word[ATCFD_MODE_LSB +: 3];
   assign mask     = cmd_word[ATCFD_MASK_LSB +: 3];
   assign fc_field = cmd_word[4:0];

   // Address mode legality; (An) on A7 flushes the stack page itself
   function automatic logic ea_legal(input logic [2:0] m,
                                     input logic [2:0] r);
      if (m == ATCFD_EA_IND || m == ATCFD_EA_D16 || m == ATCFD_EA_IDX)
         return 1'b1;
      else if (m == ATCFD_EA_ABS)
         return (r == ATCFD_ABS_SHORT) || (r == ATCFD_ABS_LONG);
      else
         return 1'b0;
   endfunction

   // Entry selected when masked code bits agree
   function automatic logic fc_match(input logic [2:0] e,
                                     input logic [2:0] f,
                                     input logic [2:0] m);
      return ((e ^ f) & m) == 3'h0;
   endfunction

   assign op_ok = (op_word[15:ATCFD_PREFIX_LSB] == ATCFD_OP_PREFIX)
                && (cmd_word[15:ATCFD_CMD_TOP_LSB] == ATCFD_CMD_PREFIX)
                && (cmd_word[9:8] == ATCFD_CMD_ZERO);
   assign ea_ok = ea_legal(ea_mode, ea_reg);

   always_comb begin
      fc_ok  = 1'b1;
      fc_val = 3'h0;
      if (fc_field[4:3] == ATCFD_FCS_IMM) begin
         fc_val = fc_field[2:0];
      end else if (fc_field[4:3] == ATCFD_FCS_DREG) begin
         fc_val = data_reg_value[2:0];
      end else if (fc_field == ATCFD_FCS_SRC) begin
         fc_val = source_fc_register;
      end else if (fc_field == ATCFD_FCS_DST) begin
         fc_val = dest_fc_register;
      end else begin
         fc_ok = 1'b0;
      end
   end

   // ----------------------------------------
   // Operation select
   // ----------------------------------------
   always_comb begin
      fmt_ok = 1'b0;
      case (opm)
         ATCFD_OPM_ALL:   fmt_ok = 1'b1;
         ATCFD_OPM_FC:    fmt_ok = fc_ok;
         ATCFD_OPM_FC_EA: fmt_ok = fc_ok && ea_ok;
         default:         fmt_ok = 1'b0;
      endcase
      fmt_ok = fmt_ok && op_ok;
   end

   // ----------------------------------------
   // Tag store and kill vector
   // ----------------------------------------
   logic [2:0]                 tag_fc   [ATCFD_ENTRIES];
   logic [ATCFD_PAGE_BITS-1:0] tag_page [ATCFD_ENTRIES];

   genvar g;
   generate
      for (g = 0; g < ATCFD_ENTRIES; g++) begin : g_ent
         logic hit_fc;
         logic hit_pg;
         assign hit_fc = fc_match(tag_fc[g], fc_val, mask);
         // The address itself, not memory at it, is compared
         assign hit_pg = tag_page[g] ==
                         eff_addr[31 -: ATCFD_PAGE_BITS];
         always_comb begin
            next_kill[g] = 1'b0;
            case (opm)
               ATCFD_OPM_ALL:   next_kill[g] = 1'b1;
               ATCFD_OPM_FC:    next_kill[g] = hit_fc;
               ATCFD_OPM_FC_EA: next_kill[g] = hit_fc && hit_pg;
               default:         next_kill[g] = 1'b0;
            endcase
         end
         always_ff @(posedge sys_clk) begin
            if (fill && fill_index == 3'(g)) begin
               tag_fc[g]   <= fill_fc;
               tag_page[g] <= fill_page;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Valid bits
   // ----------------------------------------
   logic do_flush;
   assign do_flush = issue && supervisor && fmt_ok;

   // Fill in the flush cycle loses to the flush for safety, but only at an entry that the flush kills
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         entry_valid <= ATCFD_VALID_RST;
      end else begin
         for (int i = 0; i < ATCFD_ENTRIES; i++) begin
            if (do_flush && next_kill[i])
               entry_valid[i] <= 1'b0;
            else if (fill && fill_index == 3'(i))
               entry_valid[i] <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Results; no condition code output exists
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         done         <= 1'b0;
         priv_trap    <= 1'b0;
         illegal      <= 1'b0;
         flush_strobe <= 1'b0;
         flush_addr   <= 32'h0;
         data_reg_sel <= 3'h0;
      end else begin
         done         <= issue;
         priv_trap    <= issue && !supervisor;
         illegal      <= issue && supervisor && !fmt_ok;
         flush_strobe <= do_flush;
         flush_addr   <= eff_addr;
         data_reg_sel <= cmd_word[2:0];
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_user_issue;
      issue && !supervisor;
   endsequence

   chk_user_traps: assert property (@(posedge sys_clk) disable iff (rst)
      s_user_issue |=> priv_trap && !flush_strobe)
      else $error("user flush did not trap");
   chk_user_keeps: assert property (@(posedge sys_clk) disable iff (rst)
      s_user_issue and !fill |=> entry_valid == $past(entry_valid))
      else $error("user flush changed cache");
   chk_all_clears: assert property (@(posedge sys_clk) disable iff (rst)
      do_flush && opm == ATCFD_OPM_ALL |=> entry_valid == 8'h00)
      else $error("flush all left entries");
   chk_fc_clears: assert property (@(posedge sys_clk) disable iff (rst)
      do_flush && opm == ATCFD_OPM_FC && !fill
      |=> (entry_valid & $past(next_kill)) == 8'h00)
      else $error("code flush left entries");
   chk_ea_spares: assert property (@(posedge sys_clk) disable iff (rst)
      do_flush && opm == ATCFD_OPM_FC_EA && !fill
      |=> entry_valid == ($past(entry_valid) & ~$past(next_kill)))
      else $error("address flush wrong set");
   chk_bad_mode: assert property (@(posedge sys_clk) disable iff (rst)
      issue && supervisor && opm == ATCFD_OPM_FC_EA && !ea_ok
      |=> illegal && !flush_strobe)
      else $error("bad address mode accepted");
   chk_addr_pass: assert property (@(posedge sys_clk) disable iff (rst)
      do_flush |=> flush_addr == $past(eff_addr))
      else $error("flush address not passed");
   chk_imm_code: assert property (@(posedge sys_clk) disable iff (rst)
      fc_field[4:3] == ATCFD_FCS_IMM |-> fc_val == fc_field[2:0])
      else $error("immediate code wrong");
   chk_done_pulse: assert property (@(posedge sys_clk) disable iff (rst)
      issue |=> done ##1 (done == $past(issue)))
      else $error("done not one cycle after issue");
endmodule
`default_nettype wire

// ---- atcfd_pkg.sv ----
// Package for the translation cache flush decoder
`default_nettype none
package atcfd_pkg;
   // ----------------------------------------
   // Instruction word layout
   // ----------------------------------------
   localparam logic [9:0] ATCFD_OP_PREFIX   = 10'h3C0;
   localparam int         ATCFD_PREFIX_LSB  = 6;
   localparam logic [2:0] ATCFD_CMD_PREFIX  = 3'h1;
   localparam int         ATCFD_CMD_TOP_LSB = 13;
   localparam int         ATCFD_MODE_LSB    = 10;
   localparam int         ATCFD_MASK_LSB    = 5;
   localparam logic [1:0] ATCFD_CMD_ZERO    = 2'h0;
   // ----------------------------------------
   // Operation modes and operand encodings
   // ----------------------------------------
   localparam logic [2:0] ATCFD_OPM_ALL     = 3'h1;
   localparam logic [2:0] ATCFD_OPM_FC      = 3'h4;
   localparam logic [2:0] ATCFD_OPM_FC_EA   = 3'h6;
   localparam logic [1:0] ATCFD_FCS_IMM     = 2'h2;
   localparam logic [1:0] ATCFD_FCS_DREG    = 2'h1;
   localparam logic [4:0] ATCFD_FCS_SRC     = 5'h00;
   localparam logic [4:0] ATCFD_FCS_DST     = 5'h01;
   localparam logic [2:0] ATCFD_EA_IND      = 3'h2;
   localparam logic [2:0] ATCFD_EA_D16      = 3'h5;
   localparam logic [2:0] ATCFD_EA_IDX      = 3'h6;
   localparam logic [2:0] ATCFD_EA_ABS      = 3'h7;
   localparam logic [2:0] ATCFD_ABS_SHORT   = 3'h0;
   localparam logic [2:0] ATCFD_ABS_LONG    = 3'h1;
   // ----------------------------------------
   // Translation cache size and reset values
   // ----------------------------------------
   localparam int         ATCFD_ENTRIES     = 8;
   localparam int         ATCFD_PAGE_BITS   = 20;
   localparam logic [7:0] ATCFD_VALID_RST   = 8'h00;
endpackage
`default_nettype wire
